// >>> verilog/dpll_housekeeping_status.v
// Purpose: DPLL housekeeping status/control register on APB, with interrupts
// Assumes: DPLL status inputs come from logic on CLK_IN; APB clocked by CLK_IN
// Notes: One wait-free access phase; unmapped addresses answer PSLVERR
`timescale 1ns/100ps
`include "dpll_hk_consts.vh"

// Function
// (R01) Secondary loss flag mirrors monitor, read-only
// (R02) Primary loss flag mirrors monitor, read-only
// (R03) Rate select one: 65.536 MHz, zero: 32.768
// (R04) Only rate select bit is software writable
// (R05) Limit flag shows phase slope limiter active
// (R06) State field reports DPLL state machine code
// (R07) Register reads zero after reset
module dpll_housekeeping_status #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire CLK_IN,
  input wire RST_IN,
  // APB slave
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [ADDR_W-1:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output reg PREADY_OUT,
  output reg PSLVERR_OUT,
  // DPLL state machine and reference monitor
  input wire MONITOR_PRIMARY_FAILED_IN,
  input wire MONITOR_SECONDARY_FAILED_IN,
  input wire PHASE_LIMIT_ACTIVE_IN,
  input wire [2:0] DPLL_STATE_IN,
  // Synthesizer control and status mirror
  output reg OUTPUT_CLOCK_RATE_SELECT_OUT,
  output reg [15:0] DPLL_HOUSEKEEPING_OUT,
  // Interrupt
  output reg IRQ_OUT
);

  // Byte address of a word index
  function [ADDR_W-1:0] byte_addr;
    input [11:0] idx;
    begin
      byte_addr = {idx[ADDR_W-3:0], 2'b00};
    end
  endfunction

  // Reserved codes are not states; keep the last reported one
  function is_reserved_state;
    input [2:0] code;
    begin
      is_reserved_state = (code == `ST_RSVD_PRI) || (code == `ST_RSVD_SEC);
    end
  endfunction

  // Whole-address match; no partial decode, so aliases answer as unmapped
  function reg_hit;
    input [ADDR_W-1:0] addr;
    input [11:0] idx;
    begin
      reg_hit = (addr == byte_addr(idx));
    end
  endfunction

  // Housekeeping fields
  reg secondary_ref_loss_flag;
  reg primary_ref_loss_flag;
  reg output_clock_rate_select;
  reg limit_flag;
  reg [2:0] dpll_state;
  // Interrupt mask
  reg [`EV_COUNT-1:0] irq_mask;
  wire [`EV_COUNT-1:0] irq_status;

  // Bus decode
  wire setup_phase;
  wire access_write;
  wire sel_hk;
  wire sel_status;
  wire sel_mask;
  wire sel_any;
  reg [15:0] dpll_housekeeping;
  reg [31:0] next_prdata;

  // Event detection
  reg [`EV_COUNT-1:0] next_events;
  reg [`EV_COUNT-1:0] clear_strobe;
  wire [2:0] next_state;
  reg next_irq;

  assign setup_phase = PSEL_IN & ~PENABLE_IN;
  assign access_write = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
  assign sel_hk = reg_hit(PADDR_IN, `HK_REG_IDX);
  assign sel_status = reg_hit(PADDR_IN, `IRQ_STATUS_IDX);
  assign sel_mask = reg_hit(PADDR_IN, `IRQ_MASK_IDX);
  assign sel_any = sel_hk | sel_status | sel_mask;

  assign next_state = is_reserved_state(DPLL_STATE_IN) ? dpll_state : DPLL_STATE_IN;

  // Assembled register word, upper bits reserved as zero
  always @* begin
    dpll_housekeeping = `HK_RESET;
    dpll_housekeeping[`HK_SEC_LOSS_BIT] = secondary_ref_loss_flag;
    dpll_housekeeping[`HK_PRI_LOSS_BIT] = primary_ref_loss_flag;
    dpll_housekeeping[`HK_RATE_SEL_BIT] = output_clock_rate_select;
    dpll_housekeeping[`HK_LIMIT_BIT] = limit_flag;
    dpll_housekeeping[`HK_STATE_MSB:`HK_STATE_LSB] = dpll_state;
  end

  // Hardware-owned fields follow their sources every cycle, except state, which holds on reserved codes
  // Same-clock sources, so no synchroniser stages are spent here
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      secondary_ref_loss_flag <= 1'b0; // [R07]
      primary_ref_loss_flag <= 1'b0; // [R07]
      limit_flag <= 1'b0; // [R07]
      dpll_state <= `ST_TRACK_PRI; // [R07]
    end else begin
      secondary_ref_loss_flag <= MONITOR_SECONDARY_FAILED_IN; // [R01]
      primary_ref_loss_flag <= MONITOR_PRIMARY_FAILED_IN; // [R02]
      limit_flag <= PHASE_LIMIT_ACTIVE_IN; // [R05]
      dpll_state <= next_state; // [R06]
    end
  end

  // Software-owned bits
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      output_clock_rate_select <= 1'b0; // [R07]
      irq_mask <= `IRQ_MASK_RESET;
    end else if (access_write) begin
      if (sel_hk) begin
        // Other fields of the word are ignored on write
        output_clock_rate_select <= PWDATA_IN[`HK_RATE_SEL_BIT]; // [R04]
      end
      if (sel_mask) begin
        irq_mask <= PWDATA_IN[`EV_COUNT-1:0];
      end
    end
  end

  // Rising edges of the flags, and any state change, are events
  // Flags reset to the idle input level, so no false edge after reset
  always @* begin
    next_events = {`EV_COUNT{1'b0}};
    next_events[`EV_PRI_LOSS_BIT] = MONITOR_PRIMARY_FAILED_IN & ~primary_ref_loss_flag;
    next_events[`EV_SEC_LOSS_BIT] = MONITOR_SECONDARY_FAILED_IN & ~secondary_ref_loss_flag;
    next_events[`EV_LIMIT_BIT] = PHASE_LIMIT_ACTIVE_IN & ~limit_flag;
    next_events[`EV_STATE_BIT] = (next_state != dpll_state);
  end

  // Write-one-to-clear; reads and other addresses clear nothing
  always @* begin
    clear_strobe = {`EV_COUNT{1'b0}};
    if (access_write && sel_status) begin
      clear_strobe = PWDATA_IN[`EV_COUNT-1:0];
    end
  end

  // Level request while any enabled status bit stands
  always @* begin
    next_irq = |(irq_status & irq_mask);
  end

  // Set beats clear inside the status module
  sticky_event_status #(
    .WIDTH(`EV_COUNT)
  ) u_events (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .pulse_in(next_events),
    .clear_in(clear_strobe),
    .status_out(irq_status)
  );

  // Read data chosen in the setup phase so the output is a flop
  // Unmapped reads return zero alongside the error flag
  always @* begin
    next_prdata = 32'h00000000;
    if (sel_hk) begin
      next_prdata[15:0] = dpll_housekeeping;
    end else if (sel_status) begin
      next_prdata[`EV_COUNT-1:0] = irq_status;
    end else if (sel_mask) begin
      next_prdata[`EV_COUNT-1:0] = irq_mask;
    end
  end

  // Ready rises for the access phase that follows each setup phase
  // No wait states: decode settles well before the access edge
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      PRDATA_OUT <= 32'h00000000;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= setup_phase;
      PSLVERR_OUT <= setup_phase & ~sel_any;
      if (setup_phase && !PWRITE_IN) begin
        PRDATA_OUT <= next_prdata;
      end
    end
  end

  // Registered outputs; select drives the synthesizer divider choice
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      OUTPUT_CLOCK_RATE_SELECT_OUT <= 1'b0; // [R07]
      DPLL_HOUSEKEEPING_OUT <= `HK_RESET; // [R07]
      IRQ_OUT <= 1'b0;
    end else begin
      // High selects 65.536 MHz, low 32.768 MHz on the main output
      OUTPUT_CLOCK_RATE_SELECT_OUT <= output_clock_rate_select; // [R03]
      DPLL_HOUSEKEEPING_OUT <= dpll_housekeeping;
      IRQ_OUT <= next_irq;
    end
  end

endmodule // dpll_housekeeping_status

// >>> verilog/dpll_hk_consts.vh
// Purpose: Constants for the DPLL housekeeping status block
// Assumes: Included by bare name from verilog/
// Notes: Indices are word indices; byte address is index times four
`ifndef DPLL_HK_CONSTS_VH
`define DPLL_HK_CONSTS_VH

// Register word indices
`define HK_REG_IDX 12'h02e
`define IRQ_STATUS_IDX 12'h030
`define IRQ_MASK_IDX 12'h031

// Reset values
`define HK_RESET 16'h0000
`define IRQ_STATUS_RESET 4'h0
`define IRQ_MASK_RESET 4'h0

// Housekeeping field positions
`define HK_STATE_LSB 0
`define HK_STATE_MSB 2
`define HK_LIMIT_BIT 3
`define HK_RATE_SEL_BIT 4
`define HK_PRI_LOSS_BIT 5
`define HK_SEC_LOSS_BIT 6

// Interrupt event bit positions
`define EV_PRI_LOSS_BIT 0
`define EV_SEC_LOSS_BIT 1
`define EV_LIMIT_BIT 2
`define EV_STATE_BIT 3
`define EV_COUNT 4

// State codes
`define ST_TRACK_PRI 3'h0
`define ST_RSVD_PRI 3'h1
`define ST_HOLD_PRI 3'h2
`define ST_TIE_PRI 3'h3
`define ST_TRACK_SEC 3'h4
`define ST_RSVD_SEC 3'h5
`define ST_HOLD_SEC 3'h6
`define ST_TIE_SEC 3'h7

`endif

// >>> verilog/sticky_event_status.v
// Purpose: Sticky event status bits with write-one-to-clear
// Assumes: Event pulses and clear strobes on the same clock
// Notes: A set in the clearing cycle wins over the clear
`timescale 1ns/100ps
module sticky_event_status #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Events and clears
  input wire [WIDTH-1:0] pulse_in,
  input wire [WIDTH-1:0] clear_in,
  // Status
  output reg [WIDTH-1:0] status_out
);

  always @(posedge clk_in) begin
    if (rst_in) begin
      status_out <= {WIDTH{1'b0}};
    end else begin
      // Set after clear so a coincident event is kept
      status_out <= (status_out & ~clear_in) | pulse_in;
    end
  end

endmodule // sticky_event_status

// >>> dv/dpll_housekeeping_status_sva.sv
// Purpose: Assertions for the DPLL housekeeping block
// Assumes: Status inputs synchronous to CLK_IN
// Notes: Flags reach the mirror two edges after the input
`timescale 1ns/100ps
module dpll_hk_checker #(
  parameter ADDR_W = 12
) (
  // Clock, reset, bus
  input wire CLK_IN,
  input wire RST_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [ADDR_W-1:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  input wire PREADY_OUT,
  input wire PSLVERR_OUT,
  // Status and outputs
  input wire MONITOR_PRIMARY_FAILED_IN,
  input wire MONITOR_SECONDARY_FAILED_IN,
  input wire PHASE_LIMIT_ACTIVE_IN,
  input wire [2:0] DPLL_STATE_IN,
  input wire OUTPUT_CLOCK_RATE_SELECT_OUT,
  input wire [15:0] DPLL_HOUSEKEEPING_OUT,
  input wire IRQ_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  wire [15:0] hk = DPLL_HOUSEKEEPING_OUT;
  wire rate = OUTPUT_CLOCK_RATE_SELECT_OUT;
  wire wr_rate = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == 12'hb8;
  // Masks $past until two edges after reset, when it still sees reset-time inputs
  reg [1:0] age;
  always @(posedge CLK_IN) age <= RST_IN ? 2'h0 : {age[0], 1'b1};
  // Reset seen at the previous edge; starts low so time zero is not checked
  reg rst_d = 1'b0;
  always @(posedge CLK_IN) rst_d <= RST_IN;
  a_sec_loss_flag: assert property (age[1] |->
    hk[6] == $past(MONITOR_SECONDARY_FAILED_IN, 2)) else $error("Secondary loss flag wrong");
  a_pri_loss_flag: assert property (age[1] |->
    hk[5] == $past(MONITOR_PRIMARY_FAILED_IN, 2)) else $error("Primary loss flag wrong");
  a_limit_flag: assert property (age[1] |->
    hk[3] == $past(PHASE_LIMIT_ACTIVE_IN, 2)) else $error("Limit flag wrong");
  a_state_code: assert property (age[1] && $past(DPLL_STATE_IN[1:0], 2) != 2'h1 |->
    hk[2:0] == $past(DPLL_STATE_IN, 2)) else $error("State field wrong");
  a_state_hold: assert property (age[1] && $past(DPLL_STATE_IN[1:0], 2) == 2'h1 |->
    $stable(hk[2:0])) else $error("Reserved state shown");
  a_rate_write: assert property (wr_rate |-> ##2
    rate == $past(PWDATA_IN[4], 2) && hk[4] == rate) else $error("Rate select not written");
  a_rate_hold: assert property (age[1] && !$past(wr_rate, 2) |->
    $stable(rate)) else $error("Rate select changed without write");
  a_reserved_zero: assert property (hk[15:7] == 9'h0)
    else $error("Reserved bits not zero");
  a_reset_zero: assert property (disable iff (1'b0) rst_d |->
    hk == 16'h0 && !rate) else $error("Not zero after reset");
  c_rate: cover property (wr_rate && PWDATA_IN[4]);
  c_err: cover property (PSLVERR_OUT);
  c_irq: cover property (IRQ_OUT);
endmodule // dpll_hk_checker

bind dpll_housekeeping_status dpll_hk_checker #(.ADDR_W(ADDR_W)) u_chk (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .MONITOR_PRIMARY_FAILED_IN(MONITOR_PRIMARY_FAILED_IN),
  .MONITOR_SECONDARY_FAILED_IN(MONITOR_SECONDARY_FAILED_IN),
  .PHASE_LIMIT_ACTIVE_IN(PHASE_LIMIT_ACTIVE_IN), .DPLL_STATE_IN(DPLL_STATE_IN),
  .OUTPUT_CLOCK_RATE_SELECT_OUT(OUTPUT_CLOCK_RATE_SELECT_OUT),
  .DPLL_HOUSEKEEPING_OUT(DPLL_HOUSEKEEPING_OUT), .IRQ_OUT(IRQ_OUT));

// >>> dv/dpll_housekeeping_status_tb.sv
// Purpose: Self-checking bench for the DPLL housekeeping block
// Assumes: Bus answers in the access phase
// Notes: Inputs change by non-blocking assignment at the rising edge
`timescale 1ns/100ps
module dpll_housekeeping_status_tb;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pri = 0, sec = 0, lim = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, ex;
  logic [2:0] st = 0, last;
  wire [31:0] prdata;
  wire pready, perr, rate, irq;
  wire [15:0] hk;
  int err_total = 0, total_checks = 0;
  always #10 clk = ~clk;
  dpll_housekeeping_status DUT (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(perr), .MONITOR_PRIMARY_FAILED_IN(pri),
    .MONITOR_SECONDARY_FAILED_IN(sec), .PHASE_LIMIT_ACTIVE_IN(lim), .DPLL_STATE_IN(st),
    .OUTPUT_CLOCK_RATE_SELECT_OUT(rate), .DPLL_HOUSEKEEPING_OUT(hk), .IRQ_OUT(irq));
  task stop_test;
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      err_total++;
    end
  endtask
  // Called just after a rising edge; leaves one idle edge behind
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      stop_test;
    end
    rd = prdata;
    err = perr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    apb(0, 12'hb8, 0);
    chk("hk reset", 0, rd);
    chk("rate reset", 0, rate);
    apb(1, 12'hb8, 32'hffff_ffff);
    apb(0, 12'hb8, 0);
    chk("hk write", 32'h10, rd);
    chk("rate high", 1, rate);
    last = 0;
    for (int i = 0; i < 8; i++) begin
      pri <= i[0];
      sec <= i[1];
      lim <= ~i[2];
      st <= i[2:0];
      if (i[1:0] != 2'h1) last = i[2:0];
      repeat (3) @(posedge clk);
      apb(0, 12'hb8, 0);
      ex = {25'h0, i[1], i[0], 1'b1, ~i[2], last};
      chk("hk flags", ex, rd);
      chk("hk out", ex, {16'h0, hk});
    end
    apb(1, 12'hb8, 32'hffef);
    @(posedge clk);
    chk("rate low", 0, rate);
    chk("hk after write", 32'h67, {16'h0, hk});
    apb(0, 12'h100, 0);
    chk("unmapped", 1, err);
    apb(1, 12'hc4, 32'h1);
    apb(1, 12'hc0, 32'hf);
    @(posedge clk);
    chk("irq clear", 0, irq);
    pri <= 0;
    sec <= 0;
    @(posedge clk);
    pri <= 1;
    sec <= 1;
    repeat (3) @(posedge clk);
    chk("irq set", 1, irq);
    apb(1, 12'hc0, 32'h1);
    @(posedge clk);
    chk("irq masked", 0, irq);
    apb(0, 12'hc0, 0);
    chk("status", 32'h2, rd);
    stop_test;
  end
endmodule // dpll_housekeeping_status_tb
